// ==== core/sdsm_pkg.sv ====
// package: constants and types of the synthesizer divider and status block
package sdsm_pkg;
   // register byte offsets
   localparam logic [3:0] SDSM_OFS_WORD0 = 4'h0;
   localparam logic [3:0] SDSM_OFS_WORD1 = 4'h4;
   localparam logic [3:0] SDSM_OFS_STATUS = 4'h8;
   // word 0 fields
   localparam int SDSM_W0_FRAC_LO = 4;
   localparam int SDSM_W0_FRAC_HI = 18;
   localparam int SDSM_W0_INT_LO = 19;
   localparam int SDSM_W0_INT_HI = 26;
   localparam int SDSM_W0_TXRX = 27;
   localparam int SDSM_W0_SEL_LO = 29;
   localparam int SDSM_W0_SEL_HI = 31;
   // word 1 fields
   localparam int SDSM_W1_R_LO = 4;
   localparam int SDSM_W1_R_HI = 6;
   localparam int SDSM_W1_CLK_LO = 7;
   localparam int SDSM_W1_CLK_HI = 10;
   localparam int SDSM_W1_OSC_EN = 12;
   localparam int SDSM_W1_BUF_50 = 17;
   localparam int SDSM_W1_HALF = 18;
   // reset values: divided clock field 4 (divide 8), r = 1, oscillator on
   localparam logic [31:0] SDSM_WORD0_RST = 32'h0000_0000;
   localparam logic [31:0] SDSM_WORD1_RST = 32'h0000_1210;
   // divider limits
   localparam logic [7:0] SDSM_INT_MIN = 8'h17;
   localparam logic [2:0] SDSM_R_MIN = 3'h1;
   // lock detector
   localparam logic [7:0] SDSM_LOCK_ERR_NS = 8'h0f;
   localparam logic [7:0] SDSM_UNLOCK_ERR_NS = 8'h19;
   localparam logic [2:0] SDSM_LOCK_COUNT = 3'h5;
   // supply settle time seen by the host, in us, and in cycles
   localparam int SDSM_CLK_MHZ = 100;
   localparam int SDSM_SUPPLY_US = 50;
   localparam int SDSM_SUPPLY_CYC = SDSM_SUPPLY_US * SDSM_CLK_MHZ;
   // status selector code table
   localparam logic [2:0] SDSM_SEL_SUPPLY = 3'h0;
   localparam logic [2:0] SDSM_SEL_CAL = 3'h1;
   localparam logic [2:0] SDSM_SEL_LOCK = 3'h2;
   localparam logic [2:0] SDSM_SEL_LEVEL = 3'h3;
   localparam logic [2:0] SDSM_SEL_DIR = 3'h4;
   typedef enum logic [0:0] {SDSM_LK_HUNT, SDSM_LK_LOCKED} sdsm_lock_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } sdsm_wb_req_t;
endpackage

// ==== core/sdsm_top.sv ====
// module: synthesizer dividers, lock detector and status pin selector
// Operation
// - divided clock has equal high and low
// - divided clock inverted versus reference clock
// - even divide 2..30 from word1 field
// - divided clock defaults to divide eight
// - divide field zero disables divided clock
// - reference divider 1..7 feeds phase comparator
// - reference divider defaults to one
// - feedback uses 8-bit integer, 15-bit fraction
// - integer feedback value never below 23
// - ratio is integer plus fraction over 2^15
// - lo always halved, optional extra halving
// - chip enable low clears all configuration
// - word0 top three bits select status
// - status defaults to supply ready after power
// - calibration selection low while calibrating
// - lock after five good, lost at 25ns
// - level selection high when settled and readback valid
// - direction selection low transmit, high receive
// - word1 bit selects buffer termination
// - internal oscillator enable, default on
`timescale 1ns/1ps
`default_nettype none
module sdsm_top
   import sdsm_pkg::*;
#(
   parameter logic [2:0] SEL_SUPPLY = SDSM_SEL_SUPPLY,
   parameter logic [2:0] SEL_CAL = SDSM_SEL_CAL,
   parameter logic [2:0] SEL_LOCK = SDSM_SEL_LOCK,
   parameter logic [2:0] SEL_LEVEL = SDSM_SEL_LEVEL,
   parameter logic [2:0] SEL_DIR = SDSM_SEL_DIR
)
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic chip_enable_in,
   input wire sdsm_wb_req_t wb_req_in,
   output logic wb_ack_out,
   output logic [31:0] wb_dat_out,
   input wire logic supply_ready_in,
   input wire logic coarse_cal_busy_in,
   input wire logic fine_cal_busy_in,
   input wire logic level_settled_in,
   input wire logic level_readback_valid_in,
   input wire logic vco_tick_in,
   input wire logic phase_err_valid_in,
   input wire logic [7:0] phase_err_ns_in,
   output logic divided_ref_out,
   output logic pfd_ref_tick_out,
   output logic lo_tick_out,
   output logic fb_div_tick_out,
   output logic lock_out,
   output logic status_select_pin_out,
   output logic buffer_50ohm_out,
   output logic int_osc_en_out
);

   logic rst;
   logic [31:0] word0_r;
   logic [31:0] word1_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic bus_req;
   logic wr_take;
   logic [3:0] clk_half;
   logic [3:0] clk_cnt_r;
   logic [2:0] r_eff;
   logic [2:0] r_cnt_r;
   logic [1:0] pre_cnt_r;
   logic [7:0] n_int;
   logic [14:0] n_frac;
   logic [15:0] acc_sum;
   logic [14:0] acc_r;
   logic carry_r;
   logic [8:0] n_eff;
   logic [8:0] fb_cnt_r;
   logic lo_tick;
   logic [2:0] good_cnt_r;
   sdsm_lock_t lock_st_r;
   logic [2:0] sel_code;
   logic pin_nxt;

   // power down acts as a synchronous clear of everything
   assign rst = sys_rst_in | ~chip_enable_in;

   // bus slave: one wait cycle, write on the acknowledge edge
   assign bus_req = wb_req_in.cyc & wb_req_in.stb;
   assign wr_take = bus_req & ack_r & wb_req_in.we & supply_ready_in;

   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         rdat_r <= 32'h0000_0000;
      end
      else if (bus_req & ~ack_r)
      begin
         case (wb_req_in.adr[3:0])
            SDSM_OFS_WORD0: rdat_r <= word0_r;
            SDSM_OFS_WORD1: rdat_r <= word1_r;
            SDSM_OFS_STATUS: rdat_r <= {26'h000_0000, status_select_pin_out,
               supply_ready_in, coarse_cal_busy_in | fine_cal_busy_in,
               level_settled_in & level_readback_valid_in, carry_r, lock_out};
            default: rdat_r <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = rdat_r;

   // configuration words, byte lanes honoured
   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         word0_r <= SDSM_WORD0_RST;
         word1_r <= SDSM_WORD1_RST;
      end
      else if (wr_take)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_req_in.sel[b] && wb_req_in.adr[3:0] == SDSM_OFS_WORD0)
            begin
               word0_r[b*8 +: 8] <= wb_req_in.dat[b*8 +: 8];
            end
            if (wb_req_in.sel[b] && wb_req_in.adr[3:0] == SDSM_OFS_WORD1)
            begin
               word1_r[b*8 +: 8] <= wb_req_in.dat[b*8 +: 8];
            end
         end
      end
   end

   assign buffer_50ohm_out = word1_r[SDSM_W1_BUF_50];
   assign int_osc_en_out = word1_r[SDSM_W1_OSC_EN];

   // divided clock: field is half the divide, so ratio is always even
   assign clk_half = word1_r[SDSM_W1_CLK_HI:SDSM_W1_CLK_LO];

   always_ff @(posedge clk_sys_in)
   begin
      if (rst || clk_half == 4'h0)
      begin
         clk_cnt_r <= 4'h0;
      end
      else if (clk_cnt_r >= clk_half - 4'h1)
      begin
         clk_cnt_r <= 4'h0;
      end
      else
      begin
         clk_cnt_r <= clk_cnt_r + 4'h1;
      end
   end

   // toggles after the reference rising edge, so it runs inverted
   always_ff @(posedge clk_sys_in)
   begin
      if (rst || clk_half == 4'h0)
      begin
         divided_ref_out <= 1'b0;
      end
      else if (clk_cnt_r >= clk_half - 4'h1)
      begin
         divided_ref_out <= ~divided_ref_out;
      end
   end

   // reference divider for the phase comparator, zero treated as one
   assign r_eff = (word1_r[SDSM_W1_R_HI:SDSM_W1_R_LO] == 3'h0) ? SDSM_R_MIN
      : word1_r[SDSM_W1_R_HI:SDSM_W1_R_LO];

   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         r_cnt_r <= 3'h0;
         pfd_ref_tick_out <= 1'b0;
      end
      else if (r_cnt_r >= r_eff - 3'h1)
      begin
         r_cnt_r <= 3'h0;
         pfd_ref_tick_out <= 1'b1;
      end
      else
      begin
         r_cnt_r <= r_cnt_r + 3'h1;
         pfd_ref_tick_out <= 1'b0;
      end
   end

   // oscillator halving, optionally twice
   assign lo_tick = vco_tick_in & pre_cnt_r[0]
      & (~word1_r[SDSM_W1_HALF] | pre_cnt_r[1]);

   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         pre_cnt_r <= 2'h0;
         lo_tick_out <= 1'b0;
      end
      else
      begin
         if (vco_tick_in)
         begin
            pre_cnt_r <= lo_tick ? 2'h0 : pre_cnt_r + 2'h1;
         end
         lo_tick_out <= lo_tick;
      end
   end

   // fractional feedback divider, first order sigma-delta
   assign n_int = (word0_r[SDSM_W0_INT_HI:SDSM_W0_INT_LO] < SDSM_INT_MIN) ? SDSM_INT_MIN
      : word0_r[SDSM_W0_INT_HI:SDSM_W0_INT_LO];
   assign n_frac = word0_r[SDSM_W0_FRAC_HI:SDSM_W0_FRAC_LO];
   assign acc_sum = {1'b0, acc_r} + {1'b0, n_frac};
   assign n_eff = {1'b0, n_int} + {8'h00, carry_r};

   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         fb_cnt_r <= 9'h000;
         acc_r <= 15'h0000;
         carry_r <= 1'b0;
         fb_div_tick_out <= 1'b0;
      end
      else if (lo_tick && fb_cnt_r >= n_eff - 9'h001)
      begin
         fb_cnt_r <= 9'h000;
         acc_r <= acc_sum[14:0];
         carry_r <= acc_sum[15];
         fb_div_tick_out <= 1'b1;
      end
      else
      begin
         if (lo_tick)
         begin
            fb_cnt_r <= fb_cnt_r + 9'h001;
         end
         fb_div_tick_out <= 1'b0;
      end
   end

   // digital lock detector
   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         good_cnt_r <= 3'h0;
         lock_st_r <= SDSM_LK_HUNT;
      end
      else if (phase_err_valid_in)
      begin
         case (lock_st_r)
            SDSM_LK_HUNT:
            begin
               if (phase_err_ns_in >= SDSM_LOCK_ERR_NS)
               begin
                  good_cnt_r <= 3'h0;
               end
               else if (good_cnt_r == SDSM_LOCK_COUNT - 3'h1)
               begin
                  good_cnt_r <= 3'h0;
                  lock_st_r <= SDSM_LK_LOCKED;
               end
               else
               begin
                  good_cnt_r <= good_cnt_r + 3'h1;
               end
            end
            SDSM_LK_LOCKED:
            begin
               if (phase_err_ns_in >= SDSM_UNLOCK_ERR_NS)
               begin
                  lock_st_r <= SDSM_LK_HUNT;
               end
            end
            default: lock_st_r <= SDSM_LK_HUNT;
         endcase
      end
   end

   assign lock_out = (lock_st_r == SDSM_LK_LOCKED);

   // status pin selector
   assign sel_code = word0_r[SDSM_W0_SEL_HI:SDSM_W0_SEL_LO];

   always_comb
   begin
      case (sel_code)
         SEL_SUPPLY: pin_nxt = supply_ready_in;
         SEL_CAL: pin_nxt = ~(coarse_cal_busy_in | fine_cal_busy_in);
         SEL_LOCK: pin_nxt = lock_out;
         SEL_LEVEL: pin_nxt = level_settled_in & level_readback_valid_in;
         SEL_DIR: pin_nxt = word0_r[SDSM_W0_TXRX];
         default: pin_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst)
      begin
         status_select_pin_out <= 1'b0;
      end
      else
      begin
         status_select_pin_out <= pin_nxt;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst);

   property p_clk_default;
      $fell(rst) |-> clk_half == 4'h4 && r_eff == 3'h1;
   endproperty
   a_clk_default: assert property (p_clk_default) else $error("bad default dividers");

   property p_clk_off;
      clk_half == 4'h0 |=> !divided_ref_out;
   endproperty
   a_clk_off: assert property (p_clk_off) else $error("divided clock not off");

   property p_clk_half4;
      (clk_half == 4'h4 && $rose(divided_ref_out) && !wr_take) ##1 (!wr_take) [*2] |->
         (divided_ref_out && $past(divided_ref_out)) ##1 divided_ref_out ##1 !divided_ref_out;
   endproperty
   a_clk_half4: assert property (p_clk_half4) else $error("divided clock high time wrong");

   property p_ref_div3;
      (pfd_ref_tick_out && r_eff == 3'h3 && !bus_req) |=>
         !pfd_ref_tick_out ##1 !pfd_ref_tick_out ##1 (pfd_ref_tick_out || bus_req);
   endproperty
   a_ref_div3: assert property (p_ref_div3) else $error("reference divide wrong");

   property p_int_min;
      (lo_tick && fb_cnt_r < 9'h016) |=> !fb_div_tick_out;
   endproperty
   a_int_min: assert property (p_int_min) else $error("integer divide below minimum");

   property p_lock_rise;
      $rose(lock_out) |-> $past(good_cnt_r) == 3'h4 && $past(phase_err_ns_in) < 8'h0f;
   endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock set too early");

   property p_lock_loss;
      (lock_out && phase_err_valid_in && phase_err_ns_in >= 8'h19) |=> !lock_out;
   endproperty
   a_lock_loss: assert property (p_lock_loss) else $error("lock not lost");

   property p_cal_low;
      (sel_code == SEL_CAL && (coarse_cal_busy_in || fine_cal_busy_in) && !wr_take)
         |=> !status_select_pin_out;
   endproperty
   a_cal_low: assert property (p_cal_low) else $error("calibration pin not low");

   property p_dir;
      (sel_code == SEL_DIR && !wr_take) |=> status_select_pin_out == $past(word0_r[27]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction pin wrong");

   property p_pwr_clear;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         !chip_enable_in |=> word0_r == SDSM_WORD0_RST && word1_r == SDSM_WORD1_RST;
   endproperty
   a_pwr_clear: assert property (p_pwr_clear) else $error("power down kept values");

   property p_cov_lock;
      $rose(lock_out);
   endproperty
   c_cov_lock: cover property (p_cov_lock);

   property p_cov_write;
      wr_take ##1 !bus_req;
   endproperty
   c_cov_write: cover property (p_cov_write);

   property p_cov_fb;
      fb_div_tick_out && carry_r;
   endproperty
   c_cov_fb: cover property (p_cov_fb);

endmodule // sdsm_top
`default_nettype wire

// ==== verif/sdsm_far_model.sv ====
// far-side model: regulator settling and vco pulse source
`timescale 1ns/1ps
`default_nettype none
module sdsm_far_model
   import sdsm_pkg::*;
#(
   parameter int SETTLE = SDSM_SUPPLY_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic chip_enable_in,
   output logic supply_ready_out,
   output logic vco_tick_out
);
   int settle_r;
   // regulator ready only after settling, restarts on power-down
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in || !chip_enable_in)
      begin
         settle_r <= 0;
         supply_ready_out <= 1'b0;
      end
      else if (settle_r < SETTLE)
      begin
         settle_r <= settle_r + 1;
      end
      else
      begin
         supply_ready_out <= 1'b1;
      end
   end
   // vco pulse every other cycle
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         vco_tick_out <= 1'b0;
      end
      else
      begin
         vco_tick_out <= !vco_tick_out;
      end
   end
endmodule // sdsm_far_model
`default_nettype wire

// ==== verif/tb.sv ====
// testbench: register access, dividers, lock and status selection
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sdsm_pkg::*;
   logic clk, rst, ce, sup, vco, cb, fb, ls, lv, pv, ack, dro, phase_comparator, lk, pin, b50, osc, lot, fbt;
   logic [2:0] tk;
   logic [7:0] pe;
   logic [31:0] rd, q;
   sdsm_wb_req_t req;
   int fail_count, check_count, cyc_count, a, b;
   sdsm_top dut (.clk_sys_in(clk), .sys_rst_in(rst), .chip_enable_in(ce), .wb_req_in(req),
      .wb_ack_out(ack), .wb_dat_out(rd), .supply_ready_in(sup), .coarse_cal_busy_in(cb),
      .fine_cal_busy_in(fb), .level_settled_in(ls), .level_readback_valid_in(lv),
      .vco_tick_in(vco), .phase_err_valid_in(pv), .phase_err_ns_in(pe),
      .divided_ref_out(dro), .pfd_ref_tick_out(phase_comparator), .lo_tick_out(lot), .fb_div_tick_out(fbt),
      .lock_out(lk), .status_select_pin_out(pin), .buffer_50ohm_out(b50),
      .int_osc_en_out(osc));
   sdsm_far_model far (.clk_sys_in(clk), .sys_rst_in(rst), .chip_enable_in(ce),
      .supply_ready_out(sup), .vco_tick_out(vco));
   assign tk = {fbt, lot, phase_comparator};
   initial
   begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc_count++;
      if (cyc_count == 40000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: {28'h000_0000, adr}, dat: d};
      do
      begin
         @(posedge clk);
      end
      while (ack !== 1'b1);
      q = rd;
      req <= '0;
   endtask
   task automatic wait_ready;
      while (pin !== 1'b1)
         @(posedge clk);
   endtask
   task automatic seg(output int len);
      logic v;
      len = 0;
      v = dro;
      while (dro === v && len < 100)
      begin
         @(posedge clk);
         len++;
      end
   endtask
   task automatic gap(input int w, output int len);
      while (tk[w] !== 1'b1)
         @(posedge clk);
      len = 0;
      do
      begin
         @(posedge clk);
         len++;
      end
      while (tk[w] !== 1'b1 && len < 200);
   endtask
   task automatic samp(input logic [7:0] e);
      @(posedge clk);
      pv <= 1'b1;
      pe <= e;
      @(posedge clk);
      pv <= 1'b0;
   endtask
   task automatic pin_is(input logic e);
      repeat (3) @(posedge clk);
      chk({31'h0000_0000, pin}, {31'h0000_0000, e});
   endtask
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      req = '0;
      {cb, fb, ls, lv, pv} = 5'h00;
      pe = 8'h00;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_ready();
      wb(1'b0, SDSM_OFS_WORD1, 32'h0000_0000);
      chk(q, SDSM_WORD1_RST);
      chk({31'h0000_0000, osc}, 32'h0000_0001);
      wb(1'b0, SDSM_OFS_STATUS, 32'h0000_0000);
      chk(q & 32'h0000_0010, 32'h0000_0010);
      wb(1'b0, 4'hc, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      seg(a);
      seg(a);
      seg(b);
      chk(32'(a), 32'h0000_0004);
      chk(32'(b), 32'h0000_0004);
      for (int h = 1; h < 16; h += 7)
      begin
         wb(1'b1, SDSM_OFS_WORD1, 32'h0000_1010 | (32'(h) << 7));
         seg(a);
         seg(a);
         seg(b);
         chk(32'(a), 32'(h));
         chk(32'(b), 32'(h));
      end
      wb(1'b1, SDSM_OFS_WORD1, 32'h0000_1010);
      repeat (40) @(posedge clk);
      seg(a);
      chk({31'h0000_0000, dro}, 32'h0000_0000);
      chk(32'(a), 32'h0000_0064);
      for (int r = 0; r < 8; r++)
      begin
         wb(1'b1, SDSM_OFS_WORD1, 32'h0000_1200 | (32'(r) << 4));
         gap(0, a);
         gap(0, a);
         chk(32'(a), (r == 0) ? 32'h0000_0001 : 32'(r));
      end
      wb(1'b1, SDSM_OFS_WORD0, 32'h0028_0000);
      gap(1, a);
      gap(1, a);
      chk(32'(a), 32'h0000_0004);
      gap(2, a);
      gap(2, a);
      chk(32'(a), 32'h0000_005c);
      wb(1'b1, SDSM_OFS_WORD0, 32'h00bc_0000);
      gap(2, a);
      gap(2, a);
      gap(2, b);
      chk(32'(a + b), 32'h0000_00bc);
      wb(1'b1, SDSM_OFS_WORD1, 32'h0004_1210);
      gap(1, a);
      gap(1, a);
      chk(32'(a), 32'h0000_0008);
      wb(1'b1, SDSM_OFS_WORD1, 32'h0006_0210);
      repeat (2) @(posedge clk);
      chk({30'h0000_0000, b50, osc}, 32'h0000_0002);
      for (int k = 0; k < 4; k++)
         samp(8'h0e);
      samp(8'h0f);
      for (int k = 0; k < 4; k++)
         samp(8'h0e);
      chk({31'h0000_0000, lk}, 32'h0000_0000);
      samp(8'h0e);
      repeat (2) @(posedge clk);
      chk({31'h0000_0000, lk}, 32'h0000_0001);
      wb(1'b1, SDSM_OFS_WORD0, {SDSM_SEL_LOCK, 29'h0000_0000});
      pin_is(1'b1);
      samp(8'h18);
      pin_is(1'b1);
      samp(8'h19);
      pin_is(1'b0);
      wb(1'b1, SDSM_OFS_WORD0, {SDSM_SEL_CAL, 29'h0000_0000});
      pin_is(1'b1);
      cb <= 1'b1;
      pin_is(1'b0);
      cb <= 1'b0;
      fb <= 1'b1;
      pin_is(1'b0);
      fb <= 1'b0;
      wb(1'b1, SDSM_OFS_WORD0, {SDSM_SEL_LEVEL, 29'h0000_0000});
      ls <= 1'b1;
      pin_is(1'b0);
      lv <= 1'b1;
      pin_is(1'b1);
      wb(1'b1, SDSM_OFS_WORD0, {SDSM_SEL_DIR, 29'h0800_0000});
      pin_is(1'b1);
      wb(1'b1, SDSM_OFS_WORD0, {SDSM_SEL_DIR, 29'h0000_0000});
      pin_is(1'b0);
      wb(1'b0, SDSM_OFS_WORD0, 32'h0000_0000);
      chk(q, {SDSM_SEL_DIR, 29'h0000_0000});
      @(posedge clk);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0000_0000, b50}, 32'h0000_0000);
      wait_ready();
      wb(1'b0, SDSM_OFS_WORD1, 32'h0000_0000);
      chk(q, SDSM_WORD1_RST);
      wb(1'b0, SDSM_OFS_WORD0, 32'h0000_0000);
      chk(q, SDSM_WORD0_RST);
      give_verdict();
   end
endmodule // tb
`default_nettype wire
